// >>> rtl/epg_energy_pulse.sv
`timescale 1ns/10ps
module epg_energy_pulse
  import epg_pkg::*;
#(
  parameter int SAMPLE_CYC = EPG_SAMPLE_CYC,
  parameter int CAL_WIDTH_CYC = EPG_CAL_WIDTH_CYC,
  parameter int MOT_WIDTH_CYC = EPG_MOT_WIDTH_CYC,
  parameter int LED_WIDTH_CYC = EPG_LED_WIDTH_CYC
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // digitised channel samples
  input wire logic signed [15:0] voltage_in_pos,
  input wire logic signed [15:0] voltage_in_neg,
  input wire logic signed [15:0] current_in_pos,
  input wire logic signed [15:0] current_in_neg,
  // mode pins
  input wire logic direction_mode_in,
  input wire logic test_mode_strap,
  // pulse and status outputs
  output logic cal_pulse_out,
  output logic motor_phase_pos,
  output logic motor_phase_neg,
  output logic led_pulse_out,
  output logic flow_sign_out,
  output logic calib_mode_out
);

  // whole module state
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [10:0] cfg;
    logic [3:0] cfg_prog;
    logic [1:0] prog_cnt;
    logic [31:0] thresh;
    logic strap_taken;
    logic calib;
    logic [31:0] smp_cnt;
    logic smp_step;
    logic signed [31:0] v_dc;
    logic signed [31:0] i_dc;
    logic signed [16:0] v_f;
    logic signed [16:0] i_f;
    logic signed [47:0] accum;
    logic [EPG_UNIT_W-1:0] units;
    logic [31:0] unit_total;
    logic cal_trig;
    logic mot_trig;
    logic led_trig;
    logic mot_phase;
    logic flow_sign;
    logic last_neg;
  } epg_state_t;

  epg_state_t st_r;
  epg_state_t st_nxt;
  epg_sel_t sel;
  logic signed [16:0] v_raw;
  logic signed [16:0] i_raw;
  logic signed [47:0] power;
  logic [3:0] cal_shift;
  logic [3:0] mot_shift;
  logic [3:0] led_shift;
  logic [EPG_UNIT_W-1:0] units_inc;
  logic [2:0] trig_v;
  logic [2:0] pulse_v;
  logic [31:0] width_v [3];
  logic [2:0] duty_v;
  logic wr_fire;

  // field with fallback to its default when never programmed
  function automatic logic [2:0] eff_code(input logic [2:0] code, input logic prog,
                                          input logic [2:0] dflt, input logic [2:0] bad);
    eff_code = (!prog || code == bad) ? dflt : code;
  endfunction

  // is this bit of the unit count at a period boundary
  function automatic logic at_boundary(input logic [EPG_UNIT_W-1:0] cnt,
                                       input logic [3:0] shift);
    logic [EPG_UNIT_W-1:0] mask;
    mask = EPG_UNIT_W'((1 << shift) - 1);
    at_boundary = (cnt & mask) == '0;
  endfunction

  // decode effective selections
  always_comb
  begin
    logic [2:0] g;
    g = eff_code({1'b0, st_r.cfg[EPG_GAIN_LSB +: 2]}, st_r.cfg_prog[0],
                 {1'b0, EPG_GAIN_DEF}, {1'b0, EPG_GAIN_BAD});
    unique case (g[1:0])
      EPG_GAIN_DEF: sel.gain = EPG_GAIN_X20;
      EPG_GAIN_16: sel.gain = EPG_GAIN_X16;
      default: sel.gain = EPG_GAIN_X4;
    endcase
    sel.cal_sel = 2'(eff_code({1'b0, st_r.cfg[EPG_CALSEL_LSB +: 2]},
                              st_r.cfg_prog[1],
                              {1'b0, EPG_CALSEL_DEF}, 3'h4));
    sel.mot_sel = 2'(eff_code({1'b0, st_r.cfg[EPG_MOTSEL_LSB +: 2]},
                              st_r.cfg_prog[2],
                              {1'b0, EPG_MOTSEL_DEF}, 3'h4));
    sel.led_sel = eff_code(st_r.cfg[EPG_LEDSEL_LSB +: 3], st_r.cfg_prog[3],
                           EPG_LEDSEL_DEF, EPG_LEDSEL_BAD);
  end

  // unit periods: units run at 512 per 100 pulses/kWh step
  assign mot_shift = EPG_SLOW_SHIFT_BASE - {2'h0, sel.mot_sel};
  assign cal_shift = EPG_CAL_SHIFT_BASE - {2'h0, sel.mot_sel}
                     - {2'h0, sel.cal_sel};
  assign led_shift = EPG_SLOW_SHIFT_BASE - {1'b0, sel.led_sel};

  // differential inputs and gain-scaled power
  assign v_raw = 17'(voltage_in_pos) - 17'(voltage_in_neg);
  assign i_raw = 17'(current_in_pos) - 17'(current_in_neg);
  assign power = 48'(st_r.v_f * st_r.i_f * $signed({1'b0, sel.gain}));
  assign units_inc = st_r.units + 1'b1;
  assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;

  always_comb
  begin
    logic [31:0] rd;
    logic [1:0] rr;
    logic signed [47:0] acc_add;
    logic signed [31:0] v_hp;
    logic signed [31:0] i_hp;
    rd = 32'h0;
    rr = EPG_RESP_OKAY;
    acc_add = 48'sh0;
    v_hp = 32'sh0;
    i_hp = 32'sh0;
    st_nxt = st_r;
    st_nxt.cal_trig = 1'b0;
    st_nxt.mot_trig = 1'b0;
    st_nxt.led_trig = 1'b0;
    st_nxt.smp_step = 1'b0;

    // strap caught once after reset release
    if (!st_r.strap_taken)
    begin
      st_nxt.strap_taken = 1'b1;
      st_nxt.calib = test_mode_strap;
    end

    // write channel: address and data in either order
    if (s_axi_awvalid && !st_r.aw_got)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata;
    end
    if (wr_fire)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = EPG_RESP_OKAY;
      unique case (st_r.aw_addr)
        EPG_ADDR_CONFIG:
        begin
          // storage accepts two programming passes only
          if (st_r.prog_cnt < EPG_PROG_MAX)
          begin
            st_nxt.cfg = st_r.w_data[10:0];
            st_nxt.cfg_prog = '1;
            st_nxt.prog_cnt = st_r.prog_cnt + 2'h1;
          end
          else
          begin
            st_nxt.bresp = EPG_RESP_SLVERR;
          end
        end
        EPG_ADDR_THRESH:
        begin
          st_nxt.thresh = st_r.w_data;
        end
        default: st_nxt.bresp = EPG_RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end

    // read channel
    unique case (s_axi_araddr)
      EPG_ADDR_CONFIG: rd = {21'h0, st_r.cfg};
      EPG_ADDR_THRESH: rd = st_r.thresh;
      EPG_ADDR_STATUS: rd = {23'h0, st_r.cfg_prog, direction_mode_in, st_r.flow_sign,
                             st_r.calib, st_r.prog_cnt};
      EPG_ADDR_ACCUM: rd = st_r.accum[31:0];
      EPG_ADDR_UNITS: rd = st_r.unit_total;
      default: rr = EPG_RESP_SLVERR;
    endcase
    if (s_axi_arvalid && !st_r.rvalid)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd;
      st_nxt.rresp = rr;
    end
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end

    // sample cadence and high-pass filters
    if (st_r.smp_cnt >= 32'(SAMPLE_CYC - 1))
    begin
      st_nxt.smp_cnt = 32'h0;
      st_nxt.smp_step = 1'b1;
      // same filter for both channels, so no phase skew between them
      v_hp = 32'(v_raw) - (st_r.v_dc >>> EPG_HPF_SHIFT);
      i_hp = 32'(i_raw) - (st_r.i_dc >>> EPG_HPF_SHIFT);
      st_nxt.v_dc = st_r.v_dc + v_hp;
      st_nxt.i_dc = st_r.i_dc + i_hp;
      st_nxt.v_f = 17'(v_hp);
      st_nxt.i_f = 17'(i_hp);
    end
    else
    begin
      st_nxt.smp_cnt = st_r.smp_cnt + 32'h1;
    end

    // accumulate once per new sample
    if (st_r.smp_step)
    begin
      acc_add = power;
      if (!direction_mode_in && power < 0)
      begin
        acc_add = 48'sh0;
      end
      st_nxt.accum = st_r.accum + acc_add;
      st_nxt.last_neg = power < 0;
    end
    else if (st_r.accum > $signed({16'h0, st_r.thresh}))
    begin
      // one unit per cycle; the surplus stays for the next compare
      st_nxt.accum = st_r.accum - $signed({16'h0, st_r.thresh});
      st_nxt.units = units_inc;
      st_nxt.unit_total = st_r.unit_total + 32'h1;
      st_nxt.cal_trig = at_boundary(units_inc, cal_shift);
      st_nxt.mot_trig = at_boundary(units_inc, mot_shift);
      st_nxt.led_trig = at_boundary(units_inc, led_shift);
      st_nxt.flow_sign = st_r.last_neg;
    end

    // each motor pulse goes to the other phase
    if (st_r.mot_trig)
    begin
      st_nxt.mot_phase = !st_r.mot_phase;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.thresh <= EPG_THRESH_DEF;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // pulse shapers: fast test, motor, indicator
  assign trig_v = {st_r.led_trig, st_r.mot_trig, st_r.cal_trig};
  assign width_v[0] = 32'(CAL_WIDTH_CYC);
  assign width_v[1] = 32'(MOT_WIDTH_CYC);
  assign width_v[2] = 32'(LED_WIDTH_CYC);
  assign duty_v = 3'h6; // fast test pulse never switches to half duty

  for (genvar k = 0; k < 3; k++)
  begin : g_shp
    epg_pulse_shaper u_shp (
      .aclk(aclk),
      .aresetn(aresetn),
      .trig(trig_v[k]),
      .width_cyc(width_v[k]),
      .duty_mode(duty_v[k]),
      .pulse(pulse_v[k])
    );
  end

  // outputs
  assign cal_pulse_out = pulse_v[0];
  assign motor_phase_pos = pulse_v[1] && st_r.mot_phase;
  assign motor_phase_neg = pulse_v[1] && !st_r.mot_phase;
  assign led_pulse_out = pulse_v[2];
  assign flow_sign_out = st_r.flow_sign;
  assign calib_mode_out = st_r.calib;
  assign s_axi_awready = !st_r.aw_got;
  assign s_axi_wready = !st_r.w_got;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

endmodule

// >>> rtl/epg_pkg.sv
package epg_pkg;

  // clock and time base
  localparam longint EPG_CLK_HZ = 250000000;
  localparam longint EPG_MCLK_HZ = 3579545;
  localparam longint EPG_SAMPLE_MCLKS = 8 * 256;
  localparam longint EPG_CLK_PER_MS = EPG_CLK_HZ / 1000;
  localparam int EPG_SAMPLE_CYC = int'((EPG_SAMPLE_MCLKS * EPG_CLK_HZ) / EPG_MCLK_HZ);
  localparam int EPG_CAL_WIDTH_MS = 1;
  localparam int EPG_MOT_WIDTH_MS = 200;
  localparam int EPG_LED_WIDTH_MS = 80;
  localparam int EPG_CAL_WIDTH_CYC = int'(EPG_CAL_WIDTH_MS * EPG_CLK_PER_MS);
  localparam int EPG_MOT_WIDTH_CYC = int'(EPG_MOT_WIDTH_MS * EPG_CLK_PER_MS);
  localparam int EPG_LED_WIDTH_CYC = int'(EPG_LED_WIDTH_MS * EPG_CLK_PER_MS);

  // register byte addresses
  localparam logic [7:0] EPG_ADDR_CONFIG = 8'h00;
  localparam logic [7:0] EPG_ADDR_THRESH = 8'h04;
  localparam logic [7:0] EPG_ADDR_STATUS = 8'h08;
  localparam logic [7:0] EPG_ADDR_ACCUM = 8'h0c;
  localparam logic [7:0] EPG_ADDR_UNITS = 8'h10;

  // config field layout
  localparam int EPG_GAIN_LSB = 0;
  localparam int EPG_CALSEL_LSB = 2;
  localparam int EPG_MOTSEL_LSB = 4;
  localparam int EPG_LEDSEL_LSB = 6;

  // select codes and defaults
  localparam logic [1:0] EPG_GAIN_DEF = 2'h3;
  localparam logic [1:0] EPG_GAIN_BAD = 2'h1;
  localparam logic [1:0] EPG_GAIN_16 = 2'h2;
  localparam logic [1:0] EPG_CALSEL_DEF = 2'h1;
  localparam logic [1:0] EPG_MOTSEL_DEF = 2'h2;
  localparam logic [2:0] EPG_LEDSEL_DEF = 3'h5;
  localparam logic [2:0] EPG_LEDSEL_BAD = 3'h7;
  localparam logic [4:0] EPG_GAIN_X20 = 5'h14;
  localparam logic [4:0] EPG_GAIN_X16 = 5'h10;
  localparam logic [4:0] EPG_GAIN_X4 = 5'h04;
  localparam logic [1:0] EPG_PROG_MAX = 2'h2;
  localparam logic [31:0] EPG_THRESH_DEF = 32'h0010_0000;

  // unit pulses: one unit is 1/51200 kWh; shifts give each output period
  localparam logic [3:0] EPG_CAL_SHIFT_BASE = 4'h6;
  localparam logic [3:0] EPG_SLOW_SHIFT_BASE = 4'h9;
  localparam int EPG_UNIT_W = 9;
  localparam int EPG_HPF_SHIFT = 8;

  // axi responses
  localparam logic [1:0] EPG_RESP_OKAY = 2'h0;
  localparam logic [1:0] EPG_RESP_SLVERR = 2'h2;

  // effective pulse selections
  typedef struct packed {
    logic [4:0] gain;
    logic [1:0] cal_sel;
    logic [1:0] mot_sel;
    logic [2:0] led_sel;
  } epg_sel_t;

  // pulse shaper state
  typedef struct packed {
    logic high;
    logic [31:0] on_cnt;
    logic [31:0] per_cnt;
  } epg_shp_t;

endpackage

// >>> rtl/epg_pulse_shaper.sv
`timescale 1ns/10ps
// stretches a one-cycle trigger into a pulse of fixed width, or of half
// the spacing since the previous trigger when that spacing is too short
module epg_pulse_shaper
  import epg_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // trigger and shape
  input wire logic trig,
  input wire logic [31:0] width_cyc,
  input wire logic duty_mode,
  // pulse out
  output logic pulse
);

  epg_shp_t st_r;
  epg_shp_t st_nxt;
  logic [31:0] half_per;

  assign half_per = {1'b0, st_r.per_cnt[31:1]};

  // one pulse per trigger; width latched when it starts
  always_comb
  begin
    st_nxt = st_r;
    if (st_r.per_cnt != '1)
    begin
      st_nxt.per_cnt = st_r.per_cnt + 32'h1; // saturates while idle
    end
    if (st_r.on_cnt != 32'h0)
    begin
      st_nxt.on_cnt = st_r.on_cnt - 32'h1;
    end
    else
    begin
      st_nxt.high = 1'b0;
    end
    if (trig)
    begin
      st_nxt.per_cnt = 32'h0;
      st_nxt.high = 1'b1;
      // short period: keep 50 % duty instead of the fixed width
      if (duty_mode && (half_per < width_cyc))
      begin
        st_nxt.on_cnt = (half_per == 32'h0) ? 32'h0 : half_per - 32'h1;
      end
      else
      begin
        st_nxt.on_cnt = width_cyc - 32'h1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '{high: 1'b0, on_cnt: 32'h0, per_cnt: '1};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pulse = st_r.high;

endmodule

// >>> dv/epg_energy_pulse_checker.sv
`timescale 1ns/10ps
module epg_energy_pulse_checker
  import epg_pkg::*;
#(
  parameter int CAL_WIDTH_CYC = 4,
  parameter int MOT_WIDTH_CYC = 40,
  parameter int LED_WIDTH_CYC = 20
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // read channel
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // pins
  input wire logic test_mode_strap,
  input wire logic cal_pulse_out,
  input wire logic motor_phase_pos,
  input wire logic motor_phase_neg,
  input wire logic led_pulse_out,
  input wire logic calib_mode_out
);
  int cal_len_r;
  int mot_len_r;
  int led_len_r;
  int mot_gap_r;
  int led_gap_r;
  int mot_sp_r;
  int led_sp_r;
  logic neg_last_r;
  logic mot_on;

  assign mot_on = motor_phase_pos | motor_phase_neg;

  // run lengths and rise spacing; spacing stays 0 until a first rise,
  // so the first motor and led pulse is never judged; cal width is always checked
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cal_len_r <= 0;
      mot_len_r <= 0;
      led_len_r <= 0;
      mot_gap_r <= 0;
      led_gap_r <= 0;
      mot_sp_r <= 0;
      led_sp_r <= 0;
      neg_last_r <= 1'b1; // first motor pulse lands on the positive phase
    end
    else
    begin
      cal_len_r <= cal_pulse_out ? cal_len_r + 1 : 0;
      mot_len_r <= mot_on ? mot_len_r + 1 : 0;
      led_len_r <= led_pulse_out ? led_len_r + 1 : 0;
      mot_gap_r <= $rose(mot_on) ? 1 : (mot_gap_r != 0 ? mot_gap_r + 1 : 0);
      led_gap_r <= $rose(led_pulse_out) ? 1 : (led_gap_r != 0 ? led_gap_r + 1 : 0);
      if ($rose(mot_on)) mot_sp_r <= mot_gap_r;
      if ($rose(led_pulse_out)) led_sp_r <= led_gap_r;
      if ($rose(motor_phase_neg)) neg_last_r <= 1'b1;
      if ($rose(motor_phase_pos)) neg_last_r <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_cal_width: assert property ($fell(cal_pulse_out) |-> cal_len_r == CAL_WIDTH_CYC)
    else $error("cal pulse width wrong");
  a_mot_width: assert property ($fell(mot_on) && mot_sp_r > 2 * MOT_WIDTH_CYC |->
    mot_len_r == MOT_WIDTH_CYC)
    else $error("motor pulse width wrong");
  a_led_width: assert property ($fell(led_pulse_out) && led_sp_r > 2 * LED_WIDTH_CYC |->
    led_len_r == LED_WIDTH_CYC)
    else $error("led pulse width wrong");
  a_phase_excl: assert property (!(motor_phase_pos && motor_phase_neg))
    else $error("both motor phases high");
  a_pos_after_neg: assert property ($rose(motor_phase_pos) |-> neg_last_r)
    else $error("positive phase repeated");
  a_neg_after_pos: assert property ($rose(motor_phase_neg) |-> !neg_last_r)
    else $error("negative phase repeated");
  a_strap_catch: assert property ($rose(aresetn) |=> calib_mode_out == $past(test_mode_strap))
    else $error("strap not captured");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
    |=> s_axi_rresp == EPG_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind epg_energy_pulse epg_energy_pulse_checker #(
  .CAL_WIDTH_CYC(CAL_WIDTH_CYC),
  .MOT_WIDTH_CYC(MOT_WIDTH_CYC),
  .LED_WIDTH_CYC(LED_WIDTH_CYC)
) u_chk (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .test_mode_strap, .cal_pulse_out, .motor_phase_pos,
  .motor_phase_neg, .led_pulse_out, .calib_mode_out
);

// >>> dv/epg_meter_model.sv
`timescale 1ns/10ps
// far-side meter: a two-phase step counter plus pulse counters
module epg_meter_model
(
  // clock
  input wire logic aclk,
  // pulse pins
  input wire logic cal_in,
  input wire logic pos_in,
  input wire logic neg_in,
  input wire logic led_in,
  // counts
  output int cal_cnt,
  output int led_cnt,
  output int mot_cnt,
  output int step_cnt
);
  logic [3:0] q_r = 4'h0;
  logic neg_last_r = 1'b1; // first motor pulse lands on the positive phase

  // a step needs the drive to swap phase; a repeated phase is lost
  always @(posedge aclk)
  begin
    q_r <= {cal_in, pos_in, neg_in, led_in};
    if (cal_in && !q_r[3]) cal_cnt <= cal_cnt + 1;
    if (led_in && !q_r[0]) led_cnt <= led_cnt + 1;
    if ((pos_in && !q_r[2]) || (neg_in && !q_r[1])) mot_cnt <= mot_cnt + 1;
    if ((pos_in && !q_r[2] && neg_last_r) || (neg_in && !q_r[1] && !neg_last_r))
      step_cnt <= step_cnt + 1;
    if (pos_in && !q_r[2]) neg_last_r <= 1'b0;
    if (neg_in && !q_r[1]) neg_last_r <= 1'b1;
  end
endmodule

// >>> dv/epg_energy_pulse_tb.sv
`timescale 1ns/10ps
module epg_energy_pulse_tb
  import epg_pkg::*;
;
  localparam int THR = 32'h0006_0000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic signed [15:0] voltage_in_pos = 16'sh0000;
  logic signed [15:0] voltage_in_neg = 16'sh0000;
  logic signed [15:0] current_in_pos = 16'sh0000;
  logic signed [15:0] current_in_neg = 16'sh0000;
  logic direction_mode_in = 1'b1;
  logic test_mode_strap = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic cal_pulse_out, motor_phase_pos, motor_phase_neg, led_pulse_out;
  logic flow_sign_out, calib_mode_out;
  logic sgn = 1'b0;
  logic neg_pwr = 1'b0;
  int cyc = 0;
  int failures = 0;
  int compares = 0;
  int cal_cnt, led_cnt, mot_cnt, step_cnt;
  logic [31:0] d, e, f, g;

  epg_energy_pulse #(.SAMPLE_CYC(16), .CAL_WIDTH_CYC(4), .MOT_WIDTH_CYC(40),
    .LED_WIDTH_CYC(20)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .voltage_in_pos, .voltage_in_neg,
    .current_in_pos, .current_in_neg, .direction_mode_in, .test_mode_strap,
    .cal_pulse_out, .motor_phase_pos, .motor_phase_neg, .led_pulse_out,
    .flow_sign_out, .calib_mode_out);

  epg_meter_model u_meter (.aclk, .cal_in(cal_pulse_out), .pos_in(motor_phase_pos),
    .neg_in(motor_phase_neg), .led_in(led_pulse_out), .cal_cnt, .led_cnt,
    .mot_cnt, .step_cnt);

  always #2 aclk = ~aclk;

  // square wave, four samples per half period so the dc tracker sees no mean
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc[5:0] == 6'h3f) sgn <= ~sgn;
    voltage_in_pos <= sgn ? 16'sh0032 : 16'shffce;
    voltage_in_neg <= sgn ? 16'shffce : 16'sh0032;
    current_in_pos <= (sgn ^ neg_pwr) ? 16'sh0032 : 16'shffce;
    current_in_neg <= (sgn ^ neg_pwr) ? 16'shffce : 16'sh0032;
    if (cyc == 95000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    check_word({30'h0, got}, {30'h0, exp});
  endtask

  task automatic check_cnt(input longint got, input longint exp, input longint tol);
    compares++;
    if (got < exp - tol || got > exp + tol)
    begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    check_resp(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    v = s_axi_rdata;
    check_resp(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_motor();
    int m;
    m = mot_cnt;
    while (mot_cnt == m)
      @(posedge aclk);
  endtask

  // every output fires on a unit boundary shared with the motor steps,
  // so counts between two steps are exact; units may slip by one
  task automatic measure(input int cal, input int mot, input int led, input int gain);
    int c0;
    int l0;
    int t0;
    logic [31:0] u0;
    logic [31:0] u1;
    longint per;
    wait_motor();
    c0 = cal_cnt;
    l0 = led_cnt;
    t0 = cyc;
    per = longint'(512 >> mot) * 2;
    axi_read(EPG_ADDR_UNITS, u0, EPG_RESP_OKAY);
    wait_motor();
    wait_motor();
    check_cnt(cal_cnt - c0, 2 * (8 << cal), 0);
    check_cnt(led_cnt - l0, 2 * (1 << (led - mot)), 0);
    check_cnt(cyc - t0, per * 16 * THR / (10000 * gain), per * 4);
    axi_read(EPG_ADDR_UNITS, u1, EPG_RESP_OKAY);
    check_cnt(u1 - u0, per, 1);
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(EPG_ADDR_CONFIG, d, EPG_RESP_OKAY);
    check_word(d, 32'h0);
    axi_read(EPG_ADDR_THRESH, d, EPG_RESP_OKAY);
    check_word(d, EPG_THRESH_DEF);
    axi_read(EPG_ADDR_STATUS, d, EPG_RESP_OKAY);
    check_word(d, 32'h0000_0014);
    axi_read(8'h14, d, EPG_RESP_SLVERR);
    check_word(d, 32'h0);
    axi_write(EPG_ADDR_STATUS, 32'hffff_ffff, EPG_RESP_SLVERR);
    axi_write(EPG_ADDR_THRESH, THR, EPG_RESP_OKAY);
    measure(1, 2, 5, 20);
    check_word({31'h0, flow_sign_out}, 32'h0); // forward flow only so far
    check_word({31'h0, calib_mode_out}, 32'h1);
    // reversed flow in one-way mode must not reach the accumulator
    direction_mode_in <= 1'b0;
    neg_pwr <= 1'b1;
    repeat (64) @(posedge aclk);
    axi_read(EPG_ADDR_UNITS, d, EPG_RESP_OKAY);
    axi_read(EPG_ADDR_ACCUM, f, EPG_RESP_OKAY);
    repeat (2000) @(posedge aclk);
    axi_read(EPG_ADDR_UNITS, e, EPG_RESP_OKAY);
    axi_read(EPG_ADDR_ACCUM, g, EPG_RESP_OKAY);
    check_word(e, d);
    // negative energy leaking in would pull the accumulator down
    check_word(g, f);
    direction_mode_in <= 1'b1;
    neg_pwr <= 1'b0;
    axi_write(EPG_ADDR_CONFIG, 32'h0000_01f1, EPG_RESP_OKAY);
    axi_read(EPG_ADDR_CONFIG, d, EPG_RESP_OKAY);
    check_word(d, 32'h0000_01f1);
    measure(0, 3, 5, 20);
    axi_write(EPG_ADDR_CONFIG, 32'h0000_01bc, EPG_RESP_OKAY);
    measure(3, 3, 6, 4);
    axi_write(EPG_ADDR_CONFIG, 32'h0000_0031, EPG_RESP_SLVERR);
    axi_read(EPG_ADDR_CONFIG, d, EPG_RESP_OKAY);
    check_word(d, 32'h0000_01bc);
    axi_read(EPG_ADDR_STATUS, d, EPG_RESP_OKAY);
    check_word(d & 32'h3, 32'h2);
    check_cnt(step_cnt, mot_cnt, 0);
    wrap_up();
  end
endmodule
